// [rtl/ssc_pkg.sv]
// Purpose: shared constants and carriers for the stop and absolute position control
// Assumes: one 50 MHz clock, control-mode code supplied by configuration logic
// Notes:   control-mode codes are a plain local encoding
package ssc_pkg;
  // control mode codes
  localparam logic [2:0] CTL_POSITION   = 3'h0;
  localparam logic [2:0] CTL_SPEED      = 3'h1;
  localparam logic [2:0] CTL_TORQUE     = 3'h2;
  localparam logic [2:0] CTL_POS_SPEED  = 3'h3;
  localparam logic [2:0] CTL_SPD_TORQUE = 3'h4;
  localparam logic [2:0] CTL_TRQ_SPEED  = 3'h5;
  // alarm code raised by an open emergency stop
  localparam logic [7:0] ESTOP_ALARM_CODE = 8'he6;
  localparam logic [7:0] NO_ALARM_CODE    = 8'h00;
  // configuration digit position, parameter three bits [15:12]
  localparam int ABS_DIGIT_LSB = 12;
  localparam logic [3:0] ABS_DIGIT_ABS = 4'h1;
  localparam logic [3:0] ABS_DIGIT_INC = 4'h0;
  // revolution range either side of home
  localparam logic signed [16:0] REV_LIMIT = 17'sh07fff;
  localparam int ENC_BITS_DEF = 17;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_COAST = 4'h2,
    ST_BRAKE = 4'h4,
    ST_IDLE  = 4'h8
  } ssc_stop_type;

  typedef struct packed {
    logic servo_on;
    logic estop_closed;
    logic alarm;
    logic jog_req;
  } ssc_cmd_type;

  typedef struct packed {
    logic       drive_en;
    logic       dyn_brake;
    logic       jog_en;
    logic       abs_mode;
    logic       abs_refused;
    logic       estop_alarm;
    logic [7:0] estop_alarm_code;
  } ssc_stat_type;
endpackage

// [rtl/ssc_rev_counter.sv]
// Purpose: cumulative revolution counter for the absolute position
// Assumes: wrap and direction pulses are one cycle, from the encoder front end
// Notes:   saturates at plus/minus REV_LIMIT; ignores wrap pulses when not enabled
`timescale 1ns/100ps
module ssc_rev_counter
  import ssc_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_en,
  input  wire logic               i_clear,
  input  wire logic               i_wrap_up,
  input  wire logic               i_wrap_dn,
  input  wire logic signed [16:0] i_load_val,
  input  wire logic               i_load,
  output logic signed [16:0]      o_count,
  output logic                    o_overflow
);
  typedef struct packed {
    logic signed [16:0] cnt;
    logic               ovf;
  } ssc_rc_type;

  ssc_rc_type s_q;
  ssc_rc_type s_d;

  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.cnt = '0;
      s_d.ovf = 1'b0;
    end else if (i_load) begin
      s_d.cnt = i_load_val;
    end else if (i_en && i_wrap_up && !i_wrap_dn) begin
      if (s_q.cnt == REV_LIMIT) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 17'sh00001;
      end
    end else if (i_en && i_wrap_dn && !i_wrap_up) begin
      if (s_q.cnt == -REV_LIMIT) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 17'sh00001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_count    = s_q.cnt;
  assign o_overflow = s_q.ovf;
endmodule

// [rtl/ssc_top.sv]
// Purpose: stop-pattern selection and absolute position mode control of a servo amplifier
// Assumes: inputs synchronous to I_CORE_CLK; backup store kept alive by external battery
// Notes:   backup count is restored from I_BACKUP_* after reset, saved via O_BACKUP_*
// Notes on behaviour
// - servo-on off: drive off, motor coasts
// - alarm: drive off, dynamic brake on
// - estop open: drive off, brake, alarm code
// - config digit 1 absolute, 0 incremental
// - no absolute in speed, torque, switch-over
// - jog inhibited while absolute selected
// - position is revolutions plus single-turn angle
// - revolution count spans plus/minus 32767
// - home retained across power cycles
`timescale 1ns/100ps
module ssc_top
  import ssc_pkg::*;
#(
  parameter int ENC_BITS = ENC_BITS_DEF
)
(
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RESET_N,
  input  wire ssc_pkg::ssc_cmd_type  I_CMD,
  input  wire logic                  I_FWD_ROTATION_SELECT,
  input  wire logic                  I_REV_ROTATION_SELECT,
  input  wire logic [15:0]           I_CONFIG_PARAM3,
  input  wire logic [2:0]            I_CONTROL_MODE,
  input  wire logic [ENC_BITS-1:0]   I_ENC_POS,
  input  wire logic                  I_ENC_WRAP_UP,
  input  wire logic                  I_ENC_WRAP_DN,
  input  wire logic                  I_HOME_SET,
  input  wire logic                  I_BACKUP_VALID,
  input  wire logic signed [16:0]    I_BACKUP_COUNT,
  output ssc_pkg::ssc_stat_type      O_STAT,
  output logic [16+ENC_BITS:0]       O_ABS_POS,
  output logic                       O_HOMED,
  output logic                       O_REV_OVERFLOW,
  output logic                       O_BACKUP_WR,
  output logic signed [16:0]         O_BACKUP_COUNT,
  output logic [1:0]                 O_ROT_DIR
);
  import ssc_pkg::*;

  initial begin
    if (ENC_BITS < 1 || ENC_BITS > 24) begin
      $error("ENC_BITS out of range");
    end
  end

  typedef struct packed {
    ssc_stop_type          st;
    ssc_stat_type          stat;
    logic [16+ENC_BITS:0]  abs_pos;
    logic                  homed;
    logic                  restored;
    logic                  bk_wr;
    logic signed [16:0]    bk_cnt;
    logic [1:0]            dir;
  } ssc_state_type;

  ssc_state_type s_q;
  ssc_state_type s_d;

  logic               abs_sel;
  logic               mode_ok;
  logic               abs_on;
  logic signed [16:0] rev_cnt;
  logic               rev_ovf;
  logic               do_load;

  assign abs_sel = (I_CONFIG_PARAM3[ABS_DIGIT_LSB +: 4] == ABS_DIGIT_ABS);
  // only plain position control allows absolute
  assign mode_ok = (I_CONTROL_MODE == CTL_POSITION);
  assign abs_on  = abs_sel && mode_ok;
  // restore saved count once after reset
  assign do_load = !s_q.restored && I_BACKUP_VALID && abs_on;

  ssc_rev_counter u_rev (
    .i_clk      (I_CORE_CLK),
    .i_reset_n  (I_RESET_N),
    .i_en       (abs_on),
    .i_clear    (I_HOME_SET && abs_on),
    .i_wrap_up  (I_ENC_WRAP_UP),
    .i_wrap_dn  (I_ENC_WRAP_DN),
    .i_load_val (I_BACKUP_COUNT),
    .i_load     (do_load),
    .o_count    (rev_cnt),
    .o_overflow (rev_ovf)
  );

  always_comb begin
    s_d = s_q;
    s_d.bk_wr = 1'b0;
    s_d.restored = 1'b1;
    if (!I_CMD.estop_closed || I_CMD.alarm) begin
      s_d.st = ST_BRAKE;
    end else if (!I_CMD.servo_on) begin
      s_d.st = ST_COAST;
    end else begin
      s_d.st = ST_RUN;
    end
    case (s_d.st)
      ST_RUN: begin
        s_d.stat.drive_en  = 1'b1;
        s_d.stat.dyn_brake = 1'b0;
      end
      ST_COAST: begin
        s_d.stat.drive_en  = 1'b0;
        s_d.stat.dyn_brake = 1'b0;
      end
      ST_BRAKE: begin
        s_d.stat.drive_en  = 1'b0;
        s_d.stat.dyn_brake = 1'b1;
      end
      default: begin
        s_d.stat.drive_en  = 1'b0;
        s_d.stat.dyn_brake = 1'b1;
      end
    endcase
    s_d.stat.estop_alarm      = !I_CMD.estop_closed;
    s_d.stat.estop_alarm_code = I_CMD.estop_closed ? NO_ALARM_CODE : ESTOP_ALARM_CODE;
    s_d.stat.abs_mode    = abs_on;
    s_d.stat.abs_refused = abs_sel && !mode_ok;
    s_d.stat.jog_en = I_CMD.jog_req && !abs_sel && !I_CMD.alarm && I_CMD.estop_closed;
    // direction request, both or neither means no torque demand
    s_d.dir = {I_REV_ROTATION_SELECT, I_FWD_ROTATION_SELECT};
    if (I_FWD_ROTATION_SELECT == I_REV_ROTATION_SELECT) begin
      s_d.dir = 2'h0;
    end
    s_d.abs_pos = abs_on ? {rev_cnt, I_ENC_POS} : '0;
    // home marker set by restore or home set; count kept in backup store
    if (do_load) begin
      s_d.homed = 1'b1;
    end
    if (I_HOME_SET && abs_on) begin
      s_d.homed = 1'b1;
    end
    if (abs_on && s_q.homed && (rev_cnt != s_q.bk_cnt)) begin
      s_d.bk_wr  = 1'b1;
      s_d.bk_cnt = rev_cnt;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.stat.dyn_brake <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_STAT         = s_q.stat;
  assign O_ABS_POS      = s_q.abs_pos;
  assign O_HOMED        = s_q.homed;
  assign O_REV_OVERFLOW = rev_ovf;
  assign O_BACKUP_WR    = s_q.bk_wr;
  assign O_BACKUP_COUNT = s_q.bk_cnt;
  assign O_ROT_DIR      = s_q.dir;
endmodule

// [verification/ssc_properties.sv]
// Purpose: port checks of stop selection and absolute mode
// Assumes: status outputs follow inputs by one edge
// Notes:   bound into ssc_top below
`timescale 1ns/100ps
module ssc_properties
  import ssc_pkg::*;
#(
  parameter int ENC_BITS = ENC_BITS_DEF
)
(
  input wire logic                  I_CORE_CLK,
  input wire logic                  I_RESET_N,
  input wire ssc_pkg::ssc_cmd_type  I_CMD,
  input wire logic [15:0]           I_CONFIG_PARAM3,
  input wire logic [2:0]            I_CONTROL_MODE,
  input wire ssc_pkg::ssc_stat_type O_STAT,
  input wire logic [16+ENC_BITS:0]  O_ABS_POS
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic [3:0] digit = I_CONFIG_PARAM3[ABS_DIGIT_LSB+:4];
  wire logic       pos_mode = I_CONTROL_MODE == CTL_POSITION;
  sequence s_halt; !O_STAT.drive_en && O_STAT.dyn_brake; endsequence
  sequence s_coast; !O_STAT.drive_en && !O_STAT.dyn_brake; endsequence
  AST_COAST: assert property (!I_CMD.servo_on && I_CMD.estop_closed && !I_CMD.alarm
    |=> s_coast) else $error("coast expected");
  AST_ALARM: assert property (I_CMD.alarm |=> s_halt) else $error("brake expected");
  AST_ESTOP: assert property (!I_CMD.estop_closed |=> s_halt ##0 O_STAT.estop_alarm
    && O_STAT.estop_alarm_code == ESTOP_ALARM_CODE) else $error("estop code missing");
  AST_ABS: assert property (digit == ABS_DIGIT_ABS && pos_mode |=> O_STAT.abs_mode)
    else $error("absolute not selected");
  AST_INC: assert property (digit == ABS_DIGIT_INC |=> !O_STAT.abs_mode)
    else $error("incremental not selected");
  AST_REFUSE: assert property (digit == ABS_DIGIT_ABS && !pos_mode
    |=> !O_STAT.abs_mode && O_STAT.abs_refused) else $error("absolute not refused");
  AST_JOG: assert property (O_STAT.abs_mode |-> !O_STAT.jog_en) else $error("jog in abs");
  AST_ZERO: assert property (!O_STAT.abs_mode [*2] |-> O_ABS_POS == '0)
    else $error("position shown while incremental");
  AST_RANGE: assert property ($signed(O_ABS_POS[16+ENC_BITS:ENC_BITS]) <= 17'sd32767
    && $signed(O_ABS_POS[16+ENC_BITS:ENC_BITS]) >= -17'sd32767)
    else $error("revolution count out of range");
  AST_PRIO: assert property (!I_CMD.servo_on && !I_CMD.estop_closed |=> s_halt)
    else $error("coast won over brake");
endmodule
bind ssc_top ssc_properties #(.ENC_BITS(ENC_BITS)) u_props (.I_CORE_CLK, .I_RESET_N,
  .I_CMD, .I_CONFIG_PARAM3, .I_CONTROL_MODE, .O_STAT, .O_ABS_POS);

// [verification/ssc_enc_model.sv]
// Purpose: encoder far side, single-turn angle and wrap pulses
// Assumes: STEP counts per cycle while turning
// Notes:   a wrap pulse comes with the angle it produced
`timescale 1ns/100ps
module ssc_enc_model #(
  parameter int BITS = 4,
  parameter int STEP = 15
)
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_up,
  input  wire logic       i_dn,
  output logic [BITS-1:0] o_pos,
  output logic            o_wrap_up,
  output logic            o_wrap_dn
);
  always @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) begin
      {o_wrap_dn, o_wrap_up, o_pos} <= '0;
    end else begin
      o_wrap_up <= 1'b0;
      o_wrap_dn <= 1'b0;
      if (i_up) {o_wrap_up, o_pos} <= {1'b0, o_pos} + (BITS+1)'(STEP);
      if (i_dn) {o_wrap_dn, o_pos} <= {1'b0, o_pos} - (BITS+1)'(STEP);
    end
endmodule

// [verification/ssc_top_test.sv]
// Purpose: self-checking bench of ssc_top
// Assumes: ENC_BITS cut to 4 so wraps come almost every cycle
// Notes:   table of stop and mode cases, then position and retention
`timescale 1ns/100ps
module ssc_top_test;
  import ssc_pkg::*;
  logic               clk, rst_n, home, bk_valid, up, dn, wu, wd;
  logic               fwd, rev, bkw, bk_seen;
  logic [1:0]         rot;
  logic [16:0]        bkc;
  ssc_cmd_type        cmd;
  logic [15:0]        cfg;
  logic [2:0]         mode;
  logic [3:0]         enc;
  logic signed [16:0] bk_cnt;
  ssc_stat_type       stat;
  logic [20:0]        abs_pos;
  logic               homed, ovf;
  int                 n_fail, cmp_count, rev_exp;
  // {cmd, digit, mode, drive, brake, jog, abs, refused, estop alarm}
  logic [16:0] rows [13] = '{17'b1100_0000_000_100000, 17'b0100_0000_000_000000,
    17'b1110_0000_000_010000, 17'b1000_0000_000_010001, 17'b0110_0000_000_010000,
    17'b1100_0001_000_100100, 17'b1100_0001_001_100010, 17'b1100_0001_010_100010,
    17'b1100_0001_011_100010, 17'b1100_0001_100_100010, 17'b1100_0001_101_100010,
    17'b1101_0000_000_101000, 17'b1101_0001_000_100100};
  ssc_top #(.ENC_BITS(4)) dut_u (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_CMD(cmd),
    .I_FWD_ROTATION_SELECT(fwd), .I_REV_ROTATION_SELECT(rev), .I_CONFIG_PARAM3(cfg),
    .I_CONTROL_MODE(mode), .I_ENC_POS(enc), .I_ENC_WRAP_UP(wu), .I_ENC_WRAP_DN(wd),
    .I_HOME_SET(home), .I_BACKUP_VALID(bk_valid), .I_BACKUP_COUNT(bk_cnt), .O_STAT(stat),
    .O_ABS_POS(abs_pos), .O_HOMED(homed), .O_REV_OVERFLOW(ovf), .O_BACKUP_WR(bkw),
    .O_BACKUP_COUNT(bkc), .O_ROT_DIR(rot));
  ssc_enc_model enc_u (.i_clk(clk), .i_reset_n(rst_n), .i_up(up), .i_dn(dn), .o_pos(enc),
    .o_wrap_up(wu), .o_wrap_dn(wd));
  // expected count saturates like the device
  always @(posedge clk)
    if (wu && rev_exp < 32767) rev_exp <= rev_exp + 1;
    else if (wd && rev_exp > -32767) rev_exp <= rev_exp - 1;
  always @(posedge clk)
    if (bkw) bk_seen <= 1'b1;
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic spin(input int n, input logic dir_up);
    @(posedge clk);
    up <= dir_up;
    dn <= !dir_up;
    repeat (n) @(posedge clk);
    up <= 1'b0;
    dn <= 1'b0;
    step(4);
    chk("abs position", {17'(rev_exp), enc}, abs_pos);
    chk("backup count", {4'h0, 17'(rev_exp)}, {4'h0, bkc});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, home, bk_valid, up, dn, fwd, rev, bk_seen} = '0;
    {cmd, cfg, mode, bk_cnt} = '0;
    {n_fail, cmp_count, rev_exp} = '0;
    step(12);
    chk("stat in reset", 21'h1000, 21'(stat));
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      cmd <= rows[i][16:13];
      cfg <= {rows[i][12:9], 12'h000};
      mode <= rows[i][8:6];
      step(1);
      chk("stat", {rows[i][5:0], rows[i][0] ? ESTOP_ALARM_CODE : NO_ALARM_CODE}, 21'(stat));
    end
    // direction request: one select alone passes, both or neither gives none
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {rev, fwd} <= 2'(k);
      step(1);
      chk("rot dir", (k == 1 || k == 2) ? 21'(k) : 21'h0, 21'(rot));
    end
    @(posedge clk);
    {rev, fwd} <= 2'h0;
    // servo on, absolute selected in position control, with one home set pulse in the same cycle
    @(posedge clk);
    cmd <= 4'hc;
    cfg <= 16'h1000;
    mode <= CTL_POSITION;
    home <= 1'b1;
    @(posedge clk);
    home <= 1'b0;
    step(1);
    chk("homed", 21'h1, 21'(homed));
    spin(40, 1'b1);
    chk("backup write seen", 21'h1, 21'(bk_seen));
    spin(100, 1'b0);
    spin(35500, 1'b1);
    chk("overflow", 21'h1, 21'(ovf));
    // power cycle with a saved count restores position
    @(posedge clk);
    bk_valid <= 1'b1;
    bk_cnt <= 17'sh00123;
    rst_n <= 1'b0;
    step(12);
    @(posedge clk);
    rst_n <= 1'b1;
    step(3);
    chk("restored homed", 21'h1, 21'(homed));
    chk("restored count", 21'h123, 21'(abs_pos[20:4]));
    conclude();
  end
endmodule
